//--- design/csc_channel.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - divider code n accepted over the full range 00 to ff
// - internal transfer clock is prescaled clock divided by 2(n+1)
// - every character shifts exactly eight bits
// - overrun overwrites receive data and raises no receive request
// - polarity bit picks launch and sample edges of transfer clock
// - order bit: 0 sends lsb first, 1 sends msb first
// - continuous receive: buffer read re-arms reception, which starts without dummy write only on peer clock
// - channel one: two select bits pick which clock pin drives
// - two-pin clock output disables clear and request to send
// - channel two logic select inverts data at write and read
// - channel two line reversal inverts serial out and in levels
// - serial output holds high from mode select until first transfer
// - open-drain output floats during pre-transfer idle instead
// - receive-only still shifts out dummy transmit data
// - transmit-only leaves serial input readable as general input
// - clock select 0 drives clock pin, 1 takes peer clock
// - flow pin: clear input, request output, or general port
module csc_channel
  import csc_pkg::*;
#(
  parameter bit HAS_CLK_SPLIT = 1'b1,
  parameter bit HAS_LOGIC_SEL = 1'b1
)
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // control bits
  input wire logic serial_mode,
  input wire logic [7:0] div_n,
  input wire logic [1:0] clk_src,
  input wire logic ext_clk_sel,
  input wire logic clk_pol,
  input wire logic msb_first,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic cont_rx,
  input wire logic flow_disable,
  input wire logic flow_rts_sel,
  input wire logic [1:0] clk_pin_sel,
  input wire logic data_invert,
  input wire logic line_reverse,
  input wire logic open_drain,
  // cpu transmit side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // cpu receive side
  output logic rx_valid,
  input wire logic rx_read,
  output logic [7:0] rx_data,
  output logic rx_req,
  output logic overrun,
  output logic port_in,
  output logic port_flow_in,
  // pins
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n,
  input wire logic serial_in_pin,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe_n,
  input wire logic transfer_clock_pin_i,
  output logic alternate_clock_pin_o,
  output logic alternate_clock_pin_oe_n,
  output logic flow_control_pin_o,
  output logic flow_control_pin_oe_n,
  input wire logic flow_control_pin_i
);
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = d[7-i];
    return r;
  endfunction

  function automatic logic [4:0] pre_of(input logic [1:0] s);
    logic [4:0] p;
    p = CSC_PRE_F1;
    if (s == CSC_SRC_F8)
      p = CSC_PRE_F8;
    else if (s == CSC_SRC_F32)
      p = CSC_PRE_F32;
    return p;
  endfunction

  csc_state_t state;
  // latched control, frozen for a whole character
  logic l_ext, l_pol, l_msb, l_inv, l_rev, l_split, l_flow_off, l_rts;
  logic [1:0] l_pin, l_src;
  logic [7:0] l_div;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [4:0] pre_cnt;
  logic [7:0] div_cnt;
  logic sclk;
  logic started;
  logic rx_armed;
  logic [2:0] ck_sync, in_sync, cts_sync;
  logic ck_lvl, in_lvl, cts_lvl;
  logic ck_prev;
  logic edge_rise, edge_fall, launch_edge, sample_edge;
  logic split_now;
  logic bf_valid, bf_ready;
  logic [7:0] bf_data;
  logic rx_full;
  logic start_ok, rearm_go;

  // split and logic select exist only on their channel
  assign split_now = HAS_CLK_SPLIT && (clk_pin_sel != 2'h0) && !ext_clk_sel;

  // three-stage pin synchronisers, change taken when last two agree
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ck_sync <= 3'h7;
      in_sync <= 3'h7;
      cts_sync <= 3'h7;
      ck_lvl <= 1'b1;
      in_lvl <= 1'b1;
      cts_lvl <= 1'b1;
    end
    else if (clk_en)
    begin
      ck_sync <= {ck_sync[1:0], transfer_clock_pin_i};
      in_sync <= {in_sync[1:0], serial_in_pin};
      cts_sync <= {cts_sync[1:0], flow_control_pin_i};
      if (ck_sync[1] == ck_sync[2])
        ck_lvl <= ck_sync[2];
      if (in_sync[1] == in_sync[2])
        in_lvl <= in_sync[2];
      if (cts_sync[1] == cts_sync[2])
        cts_lvl <= cts_sync[2];
    end
  end

  // transmit buffer: stall upstream instead of dropping a word
  csc_buf2 u_txbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(bf_valid),
    .out_ready(bf_ready),
    .out_data(bf_data)
  );

  // prescale then divide by n+1 per half period
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt <= 5'h00;
      div_cnt <= CSC_DIV_RESET;
      sclk <= 1'b1;
    end
    else if (clk_en)
    begin
      if (state != CSC_SHIFT)
      begin
        pre_cnt <= 5'h00;
        div_cnt <= CSC_DIV_RESET;
        sclk <= clk_pol ? 1'b0 : 1'b1;
      end
      else if (pre_cnt != pre_of(l_src))
        pre_cnt <= pre_cnt + 5'h01;
      else
      begin
        pre_cnt <= 5'h00;
        // full 8-bit code, 00 gives fastest
        if (div_cnt == l_div)
        begin
          div_cnt <= CSC_DIV_RESET;
          sclk <= ~sclk;
        end
        else
          div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // edges from own divider or from peer clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ck_prev <= 1'b1;
    else if (clk_en)
      ck_prev <= l_ext ? ck_lvl : sclk;
  end
  assign edge_rise = ((l_ext ? ck_lvl : sclk) && !ck_prev);
  assign edge_fall = (!(l_ext ? ck_lvl : sclk) && ck_prev);
  // polarity 0: launch on fall, sample on rise
  assign launch_edge = (state == CSC_SHIFT) && (l_pol ? edge_rise : edge_fall);
  assign sample_edge = (state == CSC_SHIFT) && (l_pol ? edge_fall : edge_rise);

  // pin sync latency: receive needs half periods of several mclk cycles
  assign start_ok = (state == CSC_IDLE) && serial_mode && tx_enable &&
    (flow_disable || flow_rts_sel || split_now || !cts_lvl) &&
    (!ext_clk_sel || (ck_lvl != clk_pol));
  assign bf_ready = start_ok;
  // armed channel starts on peer clock with no dummy write
  assign rearm_go = cont_rx && rx_armed && ext_clk_sel && rx_enable;

  // shift engine
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= CSC_IDLE;
      shreg <= CSC_BYTE_RESET;
      bit_cnt <= 4'h0;
      {l_ext, l_pol, l_msb, l_inv, l_rev, l_split, l_flow_off, l_rts} <= 8'h00;
      l_pin <= 2'h0;
      l_src <= CSC_SRC_F1;
      l_div <= CSC_DIV_RESET;
      started <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!serial_mode)
        started <= 1'b0;
      case (state)
        CSC_IDLE:
        begin
          // controls reloaded every idle cycle, held from character start
          l_ext <= ext_clk_sel;
          l_pol <= clk_pol;
          l_msb <= msb_first;
          l_inv <= HAS_LOGIC_SEL && data_invert;
          l_rev <= HAS_LOGIC_SEL && line_reverse;
          l_split <= split_now;
          l_pin <= clk_pin_sel;
          l_flow_off <= flow_disable;
          l_rts <= flow_rts_sel;
          l_src <= clk_src;
          l_div <= div_n;
          // dummy byte still shifted for receive-only
          if (start_ok && (bf_valid || rearm_go))
          begin
            // msb-first stored reversed, lsb always leaves first
            if (!bf_valid)
              shreg <= 8'hff;
            else
              shreg <= msb_first ? rev8(HAS_LOGIC_SEL && data_invert ?
              ~bf_data : bf_data) : (HAS_LOGIC_SEL && data_invert ?
              ~bf_data : bf_data);
            bit_cnt <= 4'h0;
            started <= 1'b1;
            state <= CSC_SHIFT;
          end
        end
        CSC_SHIFT:
        begin
          if (sample_edge)
          begin
            shreg <= {in_lvl ^ l_rev, shreg[7:1]};
            if (bit_cnt == CSC_LAST_BIT)
              state <= CSC_DONE;
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        CSC_DONE:
          state <= CSC_IDLE;
        default:
          state <= CSC_IDLE;
      endcase
    end
  end

  // receive buffer, overrun and request
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_data <= CSC_BYTE_RESET;
      rx_full <= 1'b0;
      rx_valid <= 1'b0;
      rx_req <= 1'b0;
      overrun <= 1'b0;
      rx_armed <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_req <= 1'b0;
      // read re-arms reception in continuous mode
      if (rx_read && cont_rx)
        rx_armed <= 1'b1;
      if (state == CSC_DONE && rx_enable)
      begin
        // receive side inverted on read path
        rx_data <= (l_msb ? rev8(shreg) : shreg) ^ {8{l_inv}};
        rx_full <= 1'b1;
        rx_valid <= 1'b1;
        rx_armed <= 1'b0;
        if (rx_full && !(rx_read))
          overrun <= 1'b1;
        else
          rx_req <= 1'b1;
      end
      else if (rx_read)
      begin
        rx_full <= 1'b0;
        rx_valid <= 1'b0;
        overrun <= 1'b0;
      end
    end
  end

  // pin drivers, all registered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_out_pin_o <= 1'b1;
      serial_out_pin_oe_n <= 1'b1;
      transfer_clock_pin_o <= 1'b1;
      transfer_clock_pin_oe_n <= 1'b1;
      alternate_clock_pin_o <= 1'b1;
      alternate_clock_pin_oe_n <= 1'b1;
      flow_control_pin_o <= 1'b1;
      flow_control_pin_oe_n <= 1'b1;
      port_in <= 1'b1;
      port_flow_in <= 1'b1;
    end
    else if (clk_en)
    begin
      // input pin always visible as a port
      port_in <= in_lvl;
      port_flow_in <= cts_lvl;
      // high before first transfer, float if open-drain
      if (!serial_mode || !started)
      begin
        serial_out_pin_o <= 1'b1;
        serial_out_pin_oe_n <= !serial_mode || open_drain;
      end
      else if (launch_edge || state == CSC_IDLE)
      begin
        serial_out_pin_o <= (state == CSC_SHIFT ? shreg[0] :
          serial_out_pin_o ^ 1'b0) ^ (state == CSC_SHIFT ? l_rev : 1'b0);
        serial_out_pin_oe_n <= open_drain &&
          ((state == CSC_SHIFT ? shreg[0] ^ l_rev : serial_out_pin_o));
      end
      // drive the clock only when internal
      // split picks pin by select code
      transfer_clock_pin_o <= sclk;
      alternate_clock_pin_o <= sclk;
      transfer_clock_pin_oe_n <= !(serial_mode && !ext_clk_sel &&
        (!split_now || clk_pin_sel == 2'h1));
      alternate_clock_pin_oe_n <= !(serial_mode && split_now &&
        clk_pin_sel == 2'h2);
      flow_control_pin_o <= !(rx_enable && !rx_full &&
        (rx_armed || !cont_rx || state != CSC_IDLE));
      flow_control_pin_oe_n <= !(serial_mode && !flow_disable &&
        flow_rts_sel && !split_now);
    end
  end

  a_overrun_no_req: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(overrun) |-> !rx_req)
    else $error("request raised on overrun");
  a_eight_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == CSC_DONE) |-> (bit_cnt == 4'h8))
    else $error("character not eight bits");
  a_ctrl_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && state == CSC_SHIFT && $past(state) == CSC_SHIFT) |->
    $stable(l_div) && $stable(l_msb))
    else $error("control changed mid character");
  a_ext_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && ext_clk_sel) |=> (transfer_clock_pin_oe_n || !clk_en))
    else $error("clock pin driven with external clock");
  a_split_no_rts: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && split_now) |=> flow_control_pin_oe_n)
    else $error("flow pin driven during split");
  // idle output high before first transfer
  a_idle_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && !started && !$past(started)) |=> serial_out_pin_o)
    else $error("output not high before transfer");
  a_od_float: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && !started && open_drain) |=> serial_out_pin_oe_n)
    else $error("open-drain driven in idle");
  a_div_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    div_cnt <= l_div || state != CSC_SHIFT)
    else $error("divider count past code");
endmodule
`default_nettype wire

//--- design/csc_pkg.sv
package csc_pkg;
  // bit rate divider code range
  localparam logic [7:0] CSC_DIV_MIN = 8'h00;
  localparam logic [7:0] CSC_DIV_MAX = 8'hff;
  // bits in one character
  localparam int CSC_CHAR_BITS = 8;
  localparam logic [3:0] CSC_LAST_BIT = 4'h7;
  // peripheral clock prescale choices: f1, f8, f32
  localparam logic [1:0] CSC_SRC_F1 = 2'h0;
  localparam logic [1:0] CSC_SRC_F8 = 2'h1;
  localparam logic [1:0] CSC_SRC_F32 = 2'h2;
  localparam logic [4:0] CSC_PRE_F1 = 5'h00;
  localparam logic [4:0] CSC_PRE_F8 = 5'h07;
  localparam logic [4:0] CSC_PRE_F32 = 5'h1f;
  // reset values
  localparam logic [7:0] CSC_DIV_RESET = 8'h00;
  localparam logic [7:0] CSC_BYTE_RESET = 8'h00;
  // two-entry buffer
  localparam int CSC_BUF_DEPTH = 2;
  localparam int CSC_BUF_WIDTH = 8;

  typedef enum logic [2:0]
  {
    CSC_IDLE = 3'b001,
    CSC_SHIFT = 3'b010,
    CSC_DONE = 3'b100
  } csc_state_t;
endpackage

//--- design/csc_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module csc_buf2
  import csc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [CSC_BUF_WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [CSC_BUF_WIDTH-1:0] out_data
);
  logic [CSC_BUF_WIDTH-1:0] mem [CSC_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'(CSC_BUF_DEPTH));
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= CSC_BYTE_RESET;
      mem[1] <= CSC_BYTE_RESET;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_never_over: assert property (@(posedge mclk) disable iff (!rst_n)
    count <= 2'(CSC_BUF_DEPTH))
    else $error("buffer count above depth");
endmodule
`default_nettype wire

//--- testbench/csc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module csc_peer
(
  // shared clock and data lines
  input wire logic clk_line,
  input wire logic clk_pol,
  input wire logic msb_first,
  input wire logic from_dev,
  output logic to_dev,
  output logic ext_clk,
  // captured character
  output logic [7:0] got,
  output logic [3:0] cnt
);
  logic [7:0] sh;
  logic run;
  logic tog;

  initial
  begin
    run = 1'b0;
    tog = 1'b1;
    cnt = 4'h8;
    sh = 8'h00;
    got = 8'h00;
    to_dev = 1'b1;
  end

  assign ext_clk = run ? tog : ~clk_pol;

  function automatic logic pick(input logic [3:0] i);
    return sh[msb_first ? 3'h7 - i[2:0] : i[2:0]];
  endfunction

  task automatic start(input logic [7:0] b);
    sh = b;
    cnt = 4'h0;
    to_dev = pick(4'h0);
  endtask

  task automatic run_clk(input int half);
    tog = ~clk_pol;
    run = 1'b1;
    repeat (16)
    begin
      #half;
      tog = ~tog;
    end
    #half;
    run = 1'b0;
  endtask

  always @(clk_line)
  begin
    if (clk_line === ~clk_pol && cnt < 4'h8)
    begin
      got[msb_first ? 3'h7 - cnt[2:0] : cnt[2:0]] = from_dev;
      cnt = cnt + 4'h1;
      // hold time over: stale level must not linger
      if (cnt == 4'h8)
        to_dev <= #40 ~to_dev;
    end
    else if (clk_line === clk_pol && cnt < 4'h8)
      to_dev = pick(cnt);
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import csc_pkg::*;
;
  logic mclk, rst_n, clk_en, serial_mode, ext_clk_sel, clk_pol, msb_first;
  logic tx_enable, rx_enable, cont_rx, flow_disable, flow_rts_sel;
  logic data_invert, line_reverse, open_drain, tx_valid, rx_read, flow_in;
  logic [7:0] div_n, tx_data, rx_data, reqs, edges, got;
  logic [1:0] clk_src, clk_pin_sel;
  logic tx_ready, rx_valid, rx_req, overrun, port_in, port_flow_in;
  logic so_o, so_oe_n, tc_o, tc_oe_n, ac_o, ac_oe_n, fc_o, fc_oe_n;
  logic sin, ext_clk, tc_q, clk_w, dev_line;
  logic [3:0] pcnt;
  logic [15:0] gap, half_seen;
  int error_cnt, total_checks;
  logic [7:0] c_div [5] = '{8'h00, 8'h03, 8'h01, 8'hff, 8'h02};
  logic [7:0] c_byte [5] = '{8'ha5, 8'h3c, 8'h96, 8'he1, 8'h5b};
  logic [1:0] c_src [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
  logic [3:0] c_flag [5] = '{4'h0, 4'hc, 4'h6, 4'h9, 4'h3};

  // open-drain line assumed pulled up
  assign dev_line = so_oe_n ? 1'b1 : so_o;
  assign clk_w = tc_oe_n ? ext_clk : tc_o;

  csc_channel u_csc_channel (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .serial_mode(serial_mode), .div_n(div_n), .clk_src(clk_src),
    .ext_clk_sel(ext_clk_sel), .clk_pol(clk_pol), .msb_first(msb_first),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .cont_rx(cont_rx),
    .flow_disable(flow_disable), .flow_rts_sel(flow_rts_sel),
    .clk_pin_sel(clk_pin_sel), .data_invert(data_invert),
    .line_reverse(line_reverse), .open_drain(open_drain),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_read(rx_read), .rx_data(rx_data),
    .rx_req(rx_req), .overrun(overrun), .port_in(port_in),
    .port_flow_in(port_flow_in), .serial_out_pin_o(so_o),
    .serial_out_pin_oe_n(so_oe_n), .serial_in_pin(sin),
    .transfer_clock_pin_o(tc_o), .transfer_clock_pin_oe_n(tc_oe_n),
    .transfer_clock_pin_i(clk_w), .alternate_clock_pin_o(ac_o),
    .alternate_clock_pin_oe_n(ac_oe_n), .flow_control_pin_o(fc_o),
    .flow_control_pin_oe_n(fc_oe_n), .flow_control_pin_i(flow_in));

  csc_peer u_csc_peer (.clk_line(clk_w), .clk_pol(clk_pol),
    .msb_first(msb_first), .from_dev(dev_line), .to_dev(sin),
    .ext_clk(ext_clk), .got(got), .cnt(pcnt));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // half period and edge monitor on the clock pin
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 16'h0;
      half_seen <= 16'h0;
      tc_q <= 1'b1;
      edges <= 8'h0;
      reqs <= 8'h0;
    end
    else
    begin
      gap <= (tc_o != tc_q) ? 16'h1 : gap + 16'h1;
      if (tc_o != tc_q)
        half_seen <= gap;
      if (tc_o && !tc_q)
        edges <= edges + 8'h1;
      tc_q <= tc_o;
      if (rx_req)
        reqs <= reqs + 8'h1;
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, got_v);
    total_checks++;
    if (got_v !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got_v);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rd();
    rx_read = 1'b1;
    cyc(1);
    rx_read = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] w, p, input bit wr, rq);
    logic [7:0] r0, e0, m;
    int i;
    int hp;
    r0 = reqs;
    e0 = edges;
    m = {8{data_invert ^ line_reverse}};
    hp = (clk_src == CSC_SRC_F1 ? 1 : clk_src == CSC_SRC_F8 ? 8 : 32);
    hp = hp * (int'(div_n) + 1);
    u_csc_peer.start(p);
    if (wr)
    begin
      tx_data = w;
      tx_valid = 1'b1;
      for (i = 0; i < 100 && tx_ready !== 1'b1; i++)
        cyc(1);
      cyc(1);
      tx_valid = 1'b0;
    end
    if (ext_clk_sel)
    begin
      cyc(6);
      u_csc_peer.run_clk(200);
    end
    for (i = 0; i < 20000 && pcnt !== 4'h8; i++)
      cyc(1);
    cyc(8);
    if (wr)
      chk("line byte", {8'h0, w ^ m}, {8'h0, got});
    chk("rx byte", {8'h0, p ^ m}, {8'h0, rx_data});
    chk("rx req", 16'(rq), {8'h0, reqs - r0});
    if (!ext_clk_sel)
    begin
      chk("edges", 16'h8, {8'h0, edges - e0});
      chk("half period", 16'(hp), half_seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #1ms;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    {rst_n, serial_mode, ext_clk_sel, clk_pol, msb_first, cont_rx} = 6'h0;
    {flow_rts_sel, data_invert, line_reverse, open_drain} = 4'h0;
    {tx_valid, rx_read, flow_in, clk_pin_sel, clk_src} = 7'h0;
    {clk_en, tx_enable, rx_enable, flow_disable} = 4'hf;
    div_n = 8'h00;
    tx_data = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    cyc(12);
    rst_n = 1'b1;
    serial_mode = 1'b1;
    cyc(4);
    chk("idle out", 16'h1, {15'h0, so_o});
    chk("idle drive", 16'h0, {15'h0, so_oe_n});
    chk("clk out", 16'h0, {15'h0, tc_oe_n});
    open_drain = 1'b1;
    cyc(4);
    chk("od float", 16'h1, {15'h0, so_oe_n});
    open_drain = 1'b0;
    flow_in = 1'b1;
    rx_enable = 1'b0;
    cyc(6);
    chk("flow port", 16'h1, {15'h0, port_flow_in});
    chk("in port", {15'h0, sin}, {15'h0, port_in});
    rx_enable = 1'b1;
    {flow_disable, flow_rts_sel} = 2'b01;
    cyc(4);
    chk("rts drive", 16'h0, {14'h0, fc_oe_n, fc_o});
    clk_pin_sel = 2'h2;
    cyc(4);
    chk("split flow", 16'h1, {15'h0, fc_oe_n});
    chk("alt clk", 16'h0, {15'h0, ac_oe_n});
    clk_pin_sel = 2'h0;
    {flow_rts_sel, flow_in} = 2'b00;
    cyc(4);
    chk("cts input", 16'h1, {15'h0, fc_oe_n});
    for (int k = 0; k < 5; k++)
    begin
      {clk_pol, msb_first, data_invert, line_reverse} = c_flag[k];
      div_n = c_div[k];
      clk_src = c_src[k];
      cyc(4);
      xfer(c_byte[k], ~c_byte[k], 1'b1, 1'b1);
      rd();
    end
    {clk_pol, msb_first, data_invert, line_reverse} = 4'h0;
    div_n = 8'h01;
    clk_src = CSC_SRC_F8;
    cyc(4);
    xfer(8'h11, 8'h22, 1'b1, 1'b1);
    xfer(8'h33, 8'h44, 1'b1, 1'b0);
    chk("overrun", 16'h1, {15'h0, overrun});
    rd();
    ext_clk_sel = 1'b1;
    cont_rx = 1'b1;
    cyc(2);
    chk("clk input", 16'h1, {15'h0, tc_oe_n});
    xfer(8'h5a, 8'hc3, 1'b1, 1'b1);
    rd();
    xfer(8'h00, 8'h7e, 1'b0, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
